// ### core/jtp_defines.svh
// constants for the test access port: opcodes, register offsets, field positions
// assumes an 8-bit software port with a 2-bit address
`ifndef JTP_DEFINES_SVH
`define JTP_DEFINES_SVH

`define JTP_IR_W            4
`define JTP_IR_CAPTURE      4'h1
`define JTP_OP_IDCODE       4'h1
`define JTP_OP_BYPASS       4'hf
`define JTP_OP_DBG_A        4'h8
`define JTP_OP_DBG_B        4'h9
`define JTP_OP_DBG_C        4'ha
`define JTP_OP_DBG_D        4'hb

`define JTP_ADDR_W          2
`define JTP_DATA_W          8
`define JTP_REG_CSR         2'h0
`define JTP_REG_STAT        2'h1
`define JTP_CSR_DISABLE_BIT 0
`define JTP_CSR_RESET       8'h00

`define JTP_TMS_RESET_RUN   3'h5

`define JTP_BP_FLOW_BIT     0
`define JTP_BP_STEP_BIT     1
`define JTP_BP_MODE_LSB     2
`define JTP_BP_MODE_MSB     4

// arbitrary neutral identification value, lsb set as scan convention asks
`define JTP_IDCODE_DEFAULT  32'h0000_0001

`endif

// ### core/jtp_pkg.sv
// types shared by the test access port files
// assumes nothing beyond a SystemVerilog compiler
package jtp_pkg;

  // one-hot controller states
  typedef enum logic [15:0] {
    JTP_TLR   = 16'h0001,
    JTP_RTI   = 16'h0002,
    JTP_SELDR = 16'h0004,
    JTP_CAPDR = 16'h0008,
    JTP_SHDR  = 16'h0010,
    JTP_EX1DR = 16'h0020,
    JTP_PSDR  = 16'h0040,
    JTP_EX2DR = 16'h0080,
    JTP_UPDR  = 16'h0100,
    JTP_SELIR = 16'h0200,
    JTP_CAPIR = 16'h0400,
    JTP_SHIR  = 16'h0800,
    JTP_EX1IR = 16'h1000,
    JTP_PSIR  = 16'h2000,
    JTP_EX2IR = 16'h4000,
    JTP_UPIR  = 16'h8000
  } jtp_state_e;

endpackage

// ### core/jtp_scan_reg.sv
// one data register of the scan path: capture, lsb-first shift, latched update
// assumes one-cycle enables from the controller in the mclk domain
`timescale 1ns/1ns
module jtp_scan_reg #(
  parameter int         W   = 8,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         mclk,
  input  wire logic         reset,
  input  wire logic         capture_en,
  input  wire logic         shift_en,
  input  wire logic         update_en,
  input  wire logic         ser_in,
  input  wire logic [W-1:0] cap_data,
  output logic              ser_out,
  output logic [W-1:0]      par_out
);

  logic [W-1:0] sr_r;
  logic [W-1:0] sr_nxt;

  // per bit: capture parallel input or take the bit above, top bit from ser_in
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      if (i == W - 1) begin : g_top
        assign sr_nxt[i] = capture_en ? cap_data[i] : (shift_en ? ser_in : sr_r[i]);
      end else begin : g_mid
        assign sr_nxt[i] = capture_en ? cap_data[i] : (shift_en ? sr_r[i+1] : sr_r[i]);
      end
    end
  endgenerate

  // shift stage
  always_ff @(posedge mclk) begin
    if (reset) begin
      sr_r <= '0;
    end else begin
      sr_r <= sr_nxt;
    end
  end

  // latched output moves only on update, so shifting never disturbs it
  always_ff @(posedge mclk) begin
    if (reset) begin
      par_out <= RST;
    end else if (update_en) begin
      par_out <= sr_r;
    end
  end

  assign ser_out = sr_r[0];  // lsb leaves first

endmodule // jtp_scan_reg

// ### core/jtp_tap.sv
// test access port: controller, instruction register, data paths, debug chains
// assumes tck, tms, tdi come from pins and are sampled by mclk (20 MHz)
// What this block does
// - only clock, mode, data in, data out pins
// - fuse unprogrammed: port pins, controller held reset
// - active when fuse programmed and disable clear
// - pull-ups on mode, clock, data in
// - data out floats unless shifting
// - sixteen states stepped by mode on rising clock
// - power-on reset starts in test-logic-reset
// - every shift register moves lsb first
// - four-bit instruction register shifted in Shift-IR
// - captured instruction value 0x01 shifted out
// - instruction latched in Update-IR, selects path
// - capture in Capture-DR, shift out in Shift-DR
// - latched data outputs change only in Update-DR
// - five mode highs reach test-logic-reset
// - processor chain applies instructions, returns results
// - flow, step and four configurable breakpoints
// - debug needs debug fuse and no locks
// - codes 0x8 to 0xB are debug instructions
//
// The register offsets and strobed register access were decided locally.
`timescale 1ns/1ns
`include "jtp_defines.svh"
module jtp_tap #(
  parameter logic [31:0] IDCODE = `JTP_IDCODE_DEFAULT,
  parameter int          CPU_W  = 16,
  parameter int          BP_W   = 21
) (
  input  wire logic              mclk,
  input  wire logic              reset,
  input  wire logic              tck_i,
  input  wire logic              tms_i,
  input  wire logic              tdi_i,
  output logic                   tdo_o,
  output logic                   tdo_oe_n,
  output logic                   pullup_en,
  input  wire logic              port_dout,
  input  wire logic              port_oe_n,
  input  wire logic              test_port_enable_fuse,
  input  wire logic              debug_enable_fuse,
  input  wire logic [1:0]        lock_bits,
  input  wire logic [`JTP_ADDR_W-1:0] reg_addr,
  input  wire logic [`JTP_DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [`JTP_DATA_W-1:0] reg_rdata,
  input  wire logic [CPU_W-1:0]  cpu_result_in,
  output logic [CPU_W-1:0]       cpu_instr_out,
  output logic                   cpu_instr_valid,
  output logic [BP_W-1:0]        bp_cfg,
  output logic                   bp_flow_en,
  output logic                   bp_step_en,
  output logic [2:0]             bp_mode
);

  logic [`JTP_DATA_W-1:0] mcu_control_status_reg;
  logic                   test_port_disable_bit;
  logic                   active;
  logic                   dbg_on;
  logic                   tck_s1_r, tck_s2_r, tck_s3_r;
  logic                   tms_s1_r, tms_s_r;
  logic                   tdi_s1_r, tdi_s_r;
  logic                   tck_rise, tck_fall;
  jtp_pkg::jtp_state_e    state_r;
  jtp_pkg::jtp_state_e    state_nxt;
  logic [3:0]             ir_sr_r;
  logic [3:0]             ir_r;
  logic                   bypass_r;
  logic                   sel_cpu, sel_bp, sel_id;
  logic                   cap_dr, sh_dr, up_dr;
  logic                   id_out, cpu_out, bp_out;
  logic                   shift_bit;
  logic                   tdo_r;
  logic                   tdo_oe_n_r;
  logic [2:0]             tms_cnt_r;

  // software control register, disable bit reset clear
  always_ff @(posedge mclk) begin
    if (reset) begin
      mcu_control_status_reg <= `JTP_CSR_RESET;
    end else if (reg_wr && reg_addr == `JTP_REG_CSR) begin
      mcu_control_status_reg <= reg_wdata;
    end
  end

  assign test_port_disable_bit = mcu_control_status_reg[`JTP_CSR_DISABLE_BIT];

  // read data stand in the cycle after the strobe only; unmapped reads zero
  always_ff @(posedge mclk) begin
    if (reset) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        `JTP_REG_CSR:  reg_rdata <= mcu_control_status_reg;
        `JTP_REG_STAT: reg_rdata <= {ir_r, 2'h0, dbg_on, active};
        default:       reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  assign active = test_port_enable_fuse && !test_port_disable_bit;
  assign dbg_on = active && debug_enable_fuse && (lock_bits == 2'h0);
  assign pullup_en = active;

  // pin synchronisers: three pins in, no reset pin; first stages feed only second
  always_ff @(posedge mclk) begin
    if (reset) begin
      tck_s1_r <= 1'b0;
      tck_s2_r <= 1'b0;
      tck_s3_r <= 1'b0;
      tms_s1_r <= 1'b1;
      tms_s_r  <= 1'b1;
      tdi_s1_r <= 1'b1;
      tdi_s_r  <= 1'b1;
    end else begin
      tck_s1_r <= tck_i;
      tck_s2_r <= tck_s1_r;
      tck_s3_r <= tck_s2_r;
      tms_s1_r <= tms_i;
      tms_s_r  <= tms_s1_r;
      tdi_s1_r <= tdi_i;
      tdi_s_r  <= tdi_s1_r;
    end
  end

  // tms and tdi pass the same two stages as tck, so they line up with the edge
  assign tck_rise = tck_s2_r && !tck_s3_r;
  assign tck_fall = !tck_s2_r && tck_s3_r;

  always_comb begin
    case (state_r)
      jtp_pkg::JTP_TLR:   state_nxt = tms_s_r ? jtp_pkg::JTP_TLR   : jtp_pkg::JTP_RTI;
      jtp_pkg::JTP_RTI:   state_nxt = tms_s_r ? jtp_pkg::JTP_SELDR : jtp_pkg::JTP_RTI;
      jtp_pkg::JTP_SELDR: state_nxt = tms_s_r ? jtp_pkg::JTP_SELIR : jtp_pkg::JTP_CAPDR;
      jtp_pkg::JTP_CAPDR: state_nxt = tms_s_r ? jtp_pkg::JTP_EX1DR : jtp_pkg::JTP_SHDR;
      jtp_pkg::JTP_SHDR:  state_nxt = tms_s_r ? jtp_pkg::JTP_EX1DR : jtp_pkg::JTP_SHDR;
      jtp_pkg::JTP_EX1DR: state_nxt = tms_s_r ? jtp_pkg::JTP_UPDR  : jtp_pkg::JTP_PSDR;
      jtp_pkg::JTP_PSDR:  state_nxt = tms_s_r ? jtp_pkg::JTP_EX2DR : jtp_pkg::JTP_PSDR;
      jtp_pkg::JTP_EX2DR: state_nxt = tms_s_r ? jtp_pkg::JTP_UPDR  : jtp_pkg::JTP_SHDR;
      jtp_pkg::JTP_UPDR:  state_nxt = tms_s_r ? jtp_pkg::JTP_SELDR : jtp_pkg::JTP_RTI;
      jtp_pkg::JTP_SELIR: state_nxt = tms_s_r ? jtp_pkg::JTP_TLR   : jtp_pkg::JTP_CAPIR;
      jtp_pkg::JTP_CAPIR: state_nxt = tms_s_r ? jtp_pkg::JTP_EX1IR : jtp_pkg::JTP_SHIR;
      jtp_pkg::JTP_SHIR:  state_nxt = tms_s_r ? jtp_pkg::JTP_EX1IR : jtp_pkg::JTP_SHIR;
      jtp_pkg::JTP_EX1IR: state_nxt = tms_s_r ? jtp_pkg::JTP_UPIR  : jtp_pkg::JTP_PSIR;
      jtp_pkg::JTP_PSIR:  state_nxt = tms_s_r ? jtp_pkg::JTP_EX2IR : jtp_pkg::JTP_PSIR;
      jtp_pkg::JTP_EX2IR: state_nxt = tms_s_r ? jtp_pkg::JTP_UPIR  : jtp_pkg::JTP_SHIR;
      jtp_pkg::JTP_UPIR:  state_nxt = tms_s_r ? jtp_pkg::JTP_SELDR : jtp_pkg::JTP_RTI;
      default:            state_nxt = jtp_pkg::JTP_TLR;
    endcase
  end

  // reset start, held while inactive, step on rising tck
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_r <= jtp_pkg::JTP_TLR;
    end else if (!active) begin
      state_r <= jtp_pkg::JTP_TLR;
    end else if (tck_rise) begin
      state_r <= state_nxt;
    end
  end

  // capture 0x01, four-bit shift, lsb first
  always_ff @(posedge mclk) begin
    if (reset) begin
      ir_sr_r <= '0;
    end else if (tck_rise && state_r == jtp_pkg::JTP_CAPIR) begin
      ir_sr_r <= `JTP_IR_CAPTURE;
    end else if (tck_rise && state_r == jtp_pkg::JTP_SHIR) begin
      ir_sr_r <= {tdi_s_r, ir_sr_r[3:1]};
    end
  end

  // latch instruction on update; reset state restores the identity path
  always_ff @(posedge mclk) begin
    if (reset) begin
      ir_r <= `JTP_OP_IDCODE;
    end else if (state_r == jtp_pkg::JTP_TLR) begin
      ir_r <= `JTP_OP_IDCODE;
    end else if (tck_rise && state_r == jtp_pkg::JTP_UPIR) begin
      ir_r <= ir_sr_r;
    end
  end

  // debug opcodes select chains only while debug is allowed
  assign sel_cpu = dbg_on && (ir_r == `JTP_OP_DBG_A);
  assign sel_bp  = dbg_on && (ir_r == `JTP_OP_DBG_B);
  assign sel_id  = (ir_r == `JTP_OP_IDCODE);

  // capture and shift strobes, update strobe
  assign cap_dr = tck_rise && state_r == jtp_pkg::JTP_CAPDR;
  assign sh_dr  = tck_rise && state_r == jtp_pkg::JTP_SHDR;
  assign up_dr  = tck_rise && state_r == jtp_pkg::JTP_UPDR;

  // bypass stage catches every unselected code, including the spare debug codes
  always_ff @(posedge mclk) begin
    if (reset) begin
      bypass_r <= 1'b0;
    end else if (cap_dr) begin
      bypass_r <= 1'b0;
    end else if (sh_dr) begin
      bypass_r <= tdi_s_r;
    end
  end

  // identity register, capture only
  jtp_scan_reg #(.W(32), .RST('0)) u_id (
    .mclk       (mclk),
    .reset      (reset),
    .capture_en (cap_dr && sel_id),
    .shift_en   (sh_dr && sel_id),
    .update_en  (1'b0),
    .ser_in     (tdi_s_r),
    .cap_data   (IDCODE),
    .ser_out    (id_out),
    .par_out    ()
  );

  // processor chain: instruction out on update, result captured back
  jtp_scan_reg #(.W(CPU_W), .RST('0)) u_cpu (
    .mclk       (mclk),
    .reset      (reset),
    .capture_en (cap_dr && sel_cpu),
    .shift_en   (sh_dr && sel_cpu),
    .update_en  (up_dr && sel_cpu),
    .ser_in     (tdi_s_r),
    .cap_data   (cpu_result_in),
    .ser_out    (cpu_out),
    .par_out    (cpu_instr_out)
  );

  // one-cycle apply pulse beside each new processor instruction
  always_ff @(posedge mclk) begin
    if (reset) begin
      cpu_instr_valid <= 1'b0;
    end else begin
      cpu_instr_valid <= up_dr && sel_cpu;
    end
  end

  // breakpoint configuration chain, reads back its own settings
  jtp_scan_reg #(.W(BP_W), .RST('0)) u_bp (
    .mclk       (mclk),
    .reset      (reset),
    .capture_en (cap_dr && sel_bp),
    .shift_en   (sh_dr && sel_bp),
    .update_en  (up_dr && sel_bp),
    .ser_in     (tdi_s_r),
    .cap_data   (bp_cfg),
    .ser_out    (bp_out),
    .par_out    (bp_cfg)
  );

  // decoded breakpoint controls, flow and step off when debug is locked out; mode not gated
  // mode is the raw three-bit field of the chain; 5..7 pass out unchanged
  assign bp_flow_en = dbg_on && bp_cfg[`JTP_BP_FLOW_BIT];
  assign bp_step_en = dbg_on && bp_cfg[`JTP_BP_STEP_BIT];
  assign bp_mode    = bp_cfg[`JTP_BP_MODE_MSB:`JTP_BP_MODE_LSB];

  // serial bit for the current path
  always_comb begin
    if (state_r == jtp_pkg::JTP_SHIR) begin
      shift_bit = ir_sr_r[0];
    end else if (sel_id) begin
      shift_bit = id_out;
    end else if (sel_cpu) begin
      shift_bit = cpu_out;
    end else if (sel_bp) begin
      shift_bit = bp_out;
    end else begin
      shift_bit = bypass_r;
    end
  end

  // tdo moves on falling tck, floats outside shift states
  always_ff @(posedge mclk) begin
    if (reset) begin
      tdo_r      <= 1'b1;
      tdo_oe_n_r <= 1'b1;
    end else if (!active) begin
      tdo_r      <= 1'b1;
      tdo_oe_n_r <= 1'b1;
    end else if (tck_fall) begin
      tdo_r      <= shift_bit;
      tdo_oe_n_r <= !(state_r == jtp_pkg::JTP_SHIR || state_r == jtp_pkg::JTP_SHDR);
    end
  end

  // disabled port hands the data-out pin back to the port logic
  assign tdo_o    = active ? tdo_r : port_dout;
  assign tdo_oe_n = active ? tdo_oe_n_r : port_oe_n;

  // run of mode highs seen on rising tck, saturating at five
  always_ff @(posedge mclk) begin
    if (reset) begin
      tms_cnt_r <= 3'h0;
    end else if (tck_rise) begin
      if (!tms_s_r) begin
        tms_cnt_r <= 3'h0;
      end else if (tms_cnt_r != `JTP_TMS_RESET_RUN) begin
        tms_cnt_r <= tms_cnt_r + 3'h1;
      end
    end
  end

  reset_start_a: assert property (@(posedge mclk) $fell(reset) |-> state_r == jtp_pkg::JTP_TLR)
    else $error("controller not in reset state after reset");

  hold_tlr_a: assert property (@(posedge mclk) disable iff (reset)
    !test_port_enable_fuse |-> (tdo_oe_n == port_oe_n) ##1 (state_r == jtp_pkg::JTP_TLR))
    else $error("controller left reset while fuse unprogrammed");

  five_ones_a: assert property (@(posedge mclk) disable iff (reset)
    active && tms_cnt_r == `JTP_TMS_RESET_RUN |-> state_r == jtp_pkg::JTP_TLR)
    else $error("five mode highs did not reach reset state");

  ir_capture_a: assert property (@(posedge mclk) disable iff (reset)
    tck_rise && state_r == jtp_pkg::JTP_CAPIR |=> ir_sr_r == `JTP_IR_CAPTURE && state_r != jtp_pkg::JTP_CAPIR)
    else $error("instruction capture value wrong");

  ir_shift_a: assert property (@(posedge mclk) disable iff (reset)
    tck_rise && state_r == jtp_pkg::JTP_SHIR |=> ir_sr_r == {$past(tdi_s_r), $past(ir_sr_r[3:1])})
    else $error("instruction shift not lsb first");

  ir_update_a: assert property (@(posedge mclk) disable iff (reset)
    tck_rise && state_r == jtp_pkg::JTP_UPIR && !tms_s_r |=> ir_r == $past(ir_sr_r) && state_r == jtp_pkg::JTP_RTI)
    else $error("instruction not latched on update");

  tdo_float_a: assert property (@(posedge mclk) disable iff (reset)
    active && tck_fall && state_r != jtp_pkg::JTP_SHIR && state_r != jtp_pkg::JTP_SHDR |=> tdo_oe_n)
    else $error("data out driven outside shift states");

  tdo_edge_a: assert property (@(posedge mclk) disable iff (reset)
    active && !tck_fall ##1 active |-> $stable(tdo_o) && $stable(tdo_oe_n))
    else $error("data out changed away from falling tck");

  dbg_lock_a: assert property (@(posedge mclk) disable iff (reset)
    lock_bits != 2'h0 |-> !sel_cpu && !sel_bp && !bp_flow_en && !bp_step_en)
    else $error("debug reachable with lock bits set");

  dr_update_a: assert property (@(posedge mclk) disable iff (reset)
    !(up_dr && sel_cpu) |=> $stable(cpu_instr_out))
    else $error("processor chain output moved outside update");

  pull_hold_a: assert property (@(posedge mclk) disable iff (reset)
    test_port_enable_fuse && !test_port_disable_bit |-> pullup_en ##1 (pullup_en || !active))
    else $error("pull-ups off while port active");

endmodule // jtp_tap

// ### verification/jtag_tap_debug_port_bench.sv
// self-checking bench for the test access port, register port and debug chains
// assumes jtp_host_model as far side and the design's default parameters
`timescale 1ns/1ns
`include "jtp_defines.svh"
module jtag_tap_debug_port_bench;
  logic        mclk, reset, tck, tms, tdi, tdo_o, tdo_oe_n, pullup_en, port_dout, port_oe_n;
  logic        fuse, dbg_fuse, reg_wr, reg_rd, cpu_instr_valid, bp_flow_en, bp_step_en;
  logic [1:0]  lock_bits, reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  logic [15:0] cpu_result_in, cpu_instr_out;
  logic [20:0] bp_cfg;
  logic [2:0]  bp_mode;
  logic [31:0] got;
  int          n_fail, checks_done, n_valid;

  jtp_tap uut (.mclk(mclk), .reset(reset), .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo_o),
    .tdo_oe_n(tdo_oe_n), .pullup_en(pullup_en), .port_dout(port_dout), .port_oe_n(port_oe_n),
    .test_port_enable_fuse(fuse), .debug_enable_fuse(dbg_fuse), .lock_bits(lock_bits),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cpu_result_in(cpu_result_in), .cpu_instr_out(cpu_instr_out),
    .cpu_instr_valid(cpu_instr_valid), .bp_cfg(bp_cfg), .bp_flow_en(bp_flow_en),
    .bp_step_en(bp_step_en), .bp_mode(bp_mode));

  jtp_host_model host (.tck(tck), .tms(tms), .tdi(tdi), .tdo_o(tdo_o), .tdo_oe_n(tdo_oe_n), .sys_rst(reset));

  // 20 MHz system clock
  initial mclk = 1'b0;
  always #25 mclk = ~mclk;

  // count instruction pulses; a stuck-high pulse shows as an excess count
  initial n_valid = 0;
  always @(posedge mclk) if (cpu_instr_valid === 1'b1) n_valid <= n_valid + 1;

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rdchk(input logic [1:0] a, input logic [7:0] e, input string m);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk({24'h0, reg_rdata}, {24'h0, e}, m);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // watchdog: the sequence needs well under a millisecond
  initial begin
    #3000000;
    n_fail++;
    print_verdict();
  end

  initial begin
    reset = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 2'h0;
    reg_wdata = 8'h00;
    fuse = 1'b1;
    dbg_fuse = 1'b1;
    lock_bits = 2'h0;
    port_dout = 1'b0;
    port_oe_n = 1'b1;
    cpu_result_in = 16'hc35a;
    n_fail = 0;
    checks_done = 0;
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    rdchk(`JTP_REG_STAT, 8'h13, "status after reset");
    rdchk(`JTP_REG_CSR, 8'h00, "control reset value");
    rdchk(2'h3, 8'h00, "unmapped read");
    chk(pullup_en, 1'b1, "pull-ups while active");
    $display("test registers done");
    // from the power-on state a single low reaches idle
    #13;
    host.cyc(1'b0, 1'b1, got[0]);
    host.scan(1'b0, 32, 32'h0, 1'b1, got);
    chk(got, `JTP_IDCODE_DEFAULT, "identity capture");
    chk(tdo_oe_n, 1'b1, "tdo released in idle");
    $display("test identity done");
    host.scan(1'b1, 4, {28'h0, `JTP_OP_DBG_B}, 1'b1, got);
    chk(got[3:0], `JTP_IR_CAPTURE, "instruction capture");
    host.scan(1'b0, 21, 32'h0a5e0d, 1'b0, got);
    chk(bp_cfg, 21'h0, "output held until update");
    host.fin();
    chk({bp_flow_en, bp_step_en, bp_mode}, 5'b10011, "breakpoint fields");
    host.scan(1'b0, 21, 32'h2, 1'b1, got);
    chk(got[20:0], 21'h0a5e0d, "breakpoint recapture");
    chk({bp_flow_en, bp_step_en, bp_mode}, 5'b01000, "single step");
    $display("test breakpoint chain done");
    host.scan(1'b1, 4, {28'h0, `JTP_OP_DBG_A}, 1'b1, got);
    host.scan(1'b0, 16, 32'h1234, 1'b1, got);
    chk(got[15:0], 16'hc35a, "processor result");
    chk(cpu_instr_out, 16'h1234, "processor instruction");
    chk(n_valid, 1, "one instruction pulse");
    $display("test processor chain done");
    // every debug code reaches the status field; the last two act as bypass
    for (int c = 8; c < 12; c++) begin
      host.scan(1'b1, 4, c, 1'b1, got);
      rdchk(`JTP_REG_STAT, {c[3:0], 4'h3}, "instruction field");
      if (c > 9) begin
        host.scan(1'b0, 2, 32'h3, 1'b1, got);
        chk(got[1:0], 2'b10, "bypass path");
      end
    end
    $display("test debug codes done");
    // stop inside a data shift, then five highs
    #13;
    host.cyc(1'b1, 1'b1, got[0]);
    host.cyc(1'b0, 1'b1, got[0]);
    host.cyc(1'b0, 1'b1, got[0]);
    host.cyc(1'b0, 1'b1, got[0]);
    host.tlr();
    rdchk(`JTP_REG_STAT, 8'h13, "identity restored");
    $display("test forced reset done");
    // slow host loads the debug code, then the debug side is locked
    host.half = 600;
    host.scan(1'b1, 4, {28'h0, `JTP_OP_DBG_A}, 1'b1, got);
    host.half = 200;
    @(posedge mclk);
    lock_bits <= 2'b10;
    rdchk(`JTP_REG_STAT, 8'h81, "debug blocked");
    chk(bp_step_en, 1'b0, "step gated");
    host.scan(1'b0, 2, 32'h3, 1'b1, got);
    chk(got[1:0], 2'b10, "debug code as bypass");
    chk(n_valid, 1, "no update when locked");
    @(posedge mclk);
    lock_bits <= 2'b00;
    $display("test lock done");
    wr(`JTP_REG_CSR, 8'h01);
    rdchk(`JTP_REG_CSR, 8'h01, "control readback");
    wr(2'h2, 8'hff);
    rdchk(`JTP_REG_CSR, 8'h01, "unmapped write ignored");
    @(posedge mclk);
    port_dout <= 1'b0;
    port_oe_n <= 1'b0;
    @(posedge mclk);
    #1;
    chk({pullup_en, tdo_o, tdo_oe_n}, 3'b000, "port owns the pin");
    host.scan(1'b1, 4, {28'h0, `JTP_OP_DBG_B}, 1'b1, got);
    rdchk(`JTP_REG_STAT, 8'h10, "held while disabled");
    wr(`JTP_REG_CSR, 8'h00);
    rdchk(`JTP_REG_STAT, 8'h13, "enabled again");
    $display("test disable bit done");
    @(posedge mclk);
    fuse <= 1'b0;
    port_dout <= 1'b1;
    host.scan(1'b1, 4, {28'h0, `JTP_OP_DBG_B}, 1'b1, got);
    chk({tdo_o, tdo_oe_n, pullup_en}, 3'b100, "pins are port pins");
    rdchk(`JTP_REG_STAT, 8'h10, "held while fuse off");
    @(posedge mclk);
    fuse <= 1'b1;
    rdchk(`JTP_REG_STAT, 8'h13, "fuse on again");
    $display("test fuse done");
    // mid-run system reset with the port disabled; the host must see both releases
    wr(`JTP_REG_CSR, 8'h01);
    @(posedge mclk);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    rdchk(`JTP_REG_CSR, 8'h00, "control after second reset");
    rdchk(`JTP_REG_STAT, 8'h13, "status after second reset");
    chk(cpu_instr_out, 16'h0, "instruction cleared by reset");
    chk(host.n_rst_seen, 2, "host saw both resets");
    $display("test system reset done");
    print_verdict();
  end
endmodule // jtag_tap_debug_port_bench

// ### verification/jtp_host_model.sv
// far-side test controller model: drives tck, tms, tdi and reads tdo
// assumes a board pull-up on tdo and tck standing low between scans
`timescale 1ns/1ns
module jtp_host_model (
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo_o,
  input  wire logic tdo_oe_n,
  input  wire logic sys_rst
);
  int   half = 200; // half tck period; raise it to act as a slow host
  int   n_rst_seen = 0;
  logic tdo_line;

  // watch the system reset line for outside reset sources
  always @(negedge sys_rst) n_rst_seen++;

  assign tdo_line = tdo_oe_n ? 1'b1 : tdo_o;

  // tck idles low, mode and data idle high
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end

  // one tck period; tdo is read just before the rise where it has settled
  task automatic cyc(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #(half);
    q = tdo_line;
    tck = 1'b1;
    #(half);
    tck = 1'b0;
  endtask

  // five mode highs, then one low into idle
  task automatic tlr();
    logic q;
    #13;
    repeat (5) cyc(1'b1, 1'b1, q);
    cyc(1'b0, 1'b1, q);
  endtask

  // mode 1 then 0 from exit1 back to idle through update
  task automatic fin();
    logic q;
    #13;
    cyc(1'b1, 1'b1, q);
    cyc(1'b0, 1'b1, q);
  endtask

  // walk from idle into a shift, lsb first, mode high with the last bit
  task automatic scan(input logic ir, input int n, input logic [31:0] din, input logic upd,
                      output logic [31:0] dout);
    logic q;
    #13;
    dout = '0;
    cyc(1'b1, 1'b1, q);
    if (ir) cyc(1'b1, 1'b1, q);
    cyc(1'b0, 1'b1, q);
    cyc(1'b0, 1'b1, q);
    for (int i = 0; i < n; i++) begin
      cyc(i == n - 1, din[i], q);
      dout[i] = q;
    end
    if (upd) fin();
  endtask
endmodule // jtp_host_model
